// [include/pfp_pkg.sv]
`default_nettype none
package pfp_pkg;

   // ---------------------------------------------------------------
   // register bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [15:0] FLASH_STATUS_REG_OFS  = 16'h0106;
   localparam logic [15:0] PROTECT_CTRL_OFS      = 16'h0108;
   localparam logic [15:0] IRQ_STATUS_OFS        = 16'h0120;
   localparam logic [15:0] IRQ_MASK_OFS          = 16'h0121;

   // protection control field positions
   localparam int unsigned POLARITY_BIT   = 7;
   localparam int unsigned RSVD_NV_BIT    = 6;
   localparam int unsigned HIGH_DIS_BIT   = 5;
   localparam int unsigned HIGH_SIZE_MSB  = 4;
   localparam int unsigned HIGH_SIZE_LSB  = 3;
   localparam int unsigned LOW_DIS_BIT    = 2;
   localparam int unsigned LOW_SIZE_MSB   = 1;
   localparam int unsigned LOW_SIZE_LSB   = 0;

   // value held until the nonvolatile byte arrives: everything protected
   localparam logic [7:0] PROTECT_RESET    = 8'h7F;
   // value forced when the nonvolatile byte has a double-bit fault
   localparam logic [7:0] PROTECT_DBL_FAULT = 8'h7F;

   // status register: violation flag position
   localparam int unsigned VIOL_BIT = 4;

   // interrupt status / mask layout
   localparam int unsigned IRQ_VIOL_BIT   = 0;
   localparam int unsigned IRQ_REJECT_BIT = 1;
   localparam logic [7:0]  IRQ_IMPL_MASK  = 8'h03;

   // ---------------------------------------------------------------
   // program flash address map (18-bit global addresses)
   // ---------------------------------------------------------------
   localparam logic [17:0] PFLASH_TOP       = 18'h3_FFFF;
   localparam logic [17:0] LOW_WIN_BASE     = 18'h3_8000;
   localparam logic [17:0] HIGH_UNIT_BYTES  = 18'h0_0800;
   localparam logic [17:0] LOW_UNIT_BYTES   = 18'h0_0400;
   localparam logic [17:0] ONE_BYTE         = 18'h0_0001;

   // allowed scenario transitions: bit n of entry m set = m may go to n
   localparam logic [7:0] SCEN_ALLOWED [8] = '{
      8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF
   };

   // ---------------------------------------------------------------
   // controller interface
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PFP_OP_PROGRAM,
      PFP_OP_SECTOR_ERASE,
      PFP_OP_BLOCK_ERASE,
      PFP_OP_OTHER
   } pfp_op_type;

   typedef struct packed {
      logic        valid;
      pfp_op_type  op;
      logic [17:0] addr;
   } pfp_cmd_type;

   typedef struct packed {
      logic grant;
      logic refuse;
   } pfp_verdict_type;

endpackage
`default_nettype wire

// [logic/pfp_protect.sv]
`timescale 1ns/10ps
`default_nettype none

module pfp_protect (
   input  wire  logic                        i_clk,
   input  wire  logic                        i_rst_b,
   // register port
   input  wire  logic [pfp_pkg::ADDR_W-1:0]  i_addr,
   input  wire  logic [pfp_pkg::DATA_W-1:0]  i_wdata,
   input  wire  logic                        i_wr,
   input  wire  logic                        i_rd,
   output var   logic [pfp_pkg::DATA_W-1:0]  o_rdata,
   // reset-sequence nonvolatile load
   input  wire  logic                        i_nv_valid,
   input  wire  logic [7:0]                  i_nv_byte,
   input  wire  logic                        i_nv_dbl_fault,
   output var   logic                        o_loaded,
   // flash controller check port
   input  wire  pfp_pkg::pfp_cmd_type        i_cmd,
   output var   pfp_pkg::pfp_verdict_type    o_verdict,
   output var   logic                        o_launch_block,
   // interrupt
   output var   logic                        o_irq
);
   import pfp_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] protect_ctrl;
   logic       loaded;
   logic       viol_flag;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire sel_status  = (i_addr == FLASH_STATUS_REG_OFS);
   wire sel_protect = (i_addr == PROTECT_CTRL_OFS);
   wire sel_irq_st  = (i_addr == IRQ_STATUS_OFS);
   wire sel_irq_msk = (i_addr == IRQ_MASK_OFS);

   wire wr_status   = i_wr & sel_status;
   wire wr_protect  = i_wr & sel_protect & loaded;
   wire wr_irq_st   = i_wr & sel_irq_st;
   wire wr_irq_msk  = i_wr & sel_irq_msk;

   // ---------------------------------------------------------------
   // current protection fields
   // ---------------------------------------------------------------
   wire       cur_pol   = protect_ctrl[POLARITY_BIT];
   wire       cur_hdis  = protect_ctrl[HIGH_DIS_BIT];
   wire       cur_ldis  = protect_ctrl[LOW_DIS_BIT];
   wire [1:0] cur_hsize = protect_ctrl[HIGH_SIZE_MSB:HIGH_SIZE_LSB];
   wire [1:0] cur_lsize = protect_ctrl[LOW_SIZE_MSB:LOW_SIZE_LSB];

   // scenario number is the inverted triple
   wire [2:0] cur_scen = ~{cur_pol, cur_hdis, cur_ldis};

   // ---------------------------------------------------------------
   // proposed value for a software write
   // ---------------------------------------------------------------
   // size fields only move while their window is disabled, so an active
   // window can never be shrunk or shifted underneath a running check
   wire [1:0] prop_hsize = cur_hdis ? i_wdata[HIGH_SIZE_MSB:HIGH_SIZE_LSB]
                                    : cur_hsize;
   wire [1:0] prop_lsize = cur_ldis ? i_wdata[LOW_SIZE_MSB:LOW_SIZE_LSB]
                                    : cur_lsize;

   // reserved bit is not writable; it keeps whatever was loaded
   wire [7:0] prop_ctrl = {i_wdata[POLARITY_BIT],
                           protect_ctrl[RSVD_NV_BIT],
                           i_wdata[HIGH_DIS_BIT],
                           prop_hsize,
                           i_wdata[LOW_DIS_BIT],
                           prop_lsize};

   wire [2:0] prop_scen = ~{prop_ctrl[POLARITY_BIT],
                            prop_ctrl[HIGH_DIS_BIT],
                            prop_ctrl[LOW_DIS_BIT]};

   wire [7:0] allowed_row  = SCEN_ALLOWED[cur_scen];
   wire       move_ok      = allowed_row[prop_scen];
   wire       protect_take = wr_protect & move_ok;
   wire       protect_drop = wr_protect & ~move_ok;

   // ---------------------------------------------------------------
   // window geometry
   // ---------------------------------------------------------------
   // window length doubles with each size step
   wire [17:0] high_len  = HIGH_UNIT_BYTES << cur_hsize;
   wire [17:0] low_len   = LOW_UNIT_BYTES << cur_lsize;
   wire [17:0] high_base = PFLASH_TOP - high_len + ONE_BYTE;
   wire [17:0] low_last  = LOW_WIN_BASE + low_len - ONE_BYTE;

   wire in_high = (i_cmd.addr >= high_base);
   wire in_low  = (i_cmd.addr >= LOW_WIN_BASE) & (i_cmd.addr <= low_last);

   wire hit_high = ~cur_hdis & in_high;
   wire hit_low  = ~cur_ldis & in_low;
   wire hit_win  = hit_high | hit_low;

   // polarity decides whether a window hit is protected or free
   wire addr_prot = cur_pol ? hit_win : ~hit_win;

   // a block holds protected sectors unless nothing at all is protected
   wire no_prot    = cur_pol & cur_hdis & cur_ldis;
   wire block_prot = ~no_prot;

   // ---------------------------------------------------------------
   // command verdict
   // ---------------------------------------------------------------
   wire is_block = (i_cmd.op == PFP_OP_BLOCK_ERASE);
   wire is_alter = (i_cmd.op == PFP_OP_PROGRAM) |
                   (i_cmd.op == PFP_OP_SECTOR_ERASE);

   wire cmd_prot = (is_block & block_prot) |
                   (is_alter & addr_prot);

   // nothing launches while a violation is pending or before the load
   wire cmd_blocked = viol_flag | ~loaded;

   wire cmd_viol   = i_cmd.valid & ~cmd_blocked & cmd_prot;
   wire cmd_grant  = i_cmd.valid & ~cmd_blocked & ~cmd_prot;
   wire cmd_refuse = i_cmd.valid & (cmd_blocked | cmd_prot);

   // ---------------------------------------------------------------
   // flag and interrupt next values
   // ---------------------------------------------------------------
   // a new violation in the clearing cycle wins over the clear
   wire viol_clr       = wr_status & i_wdata[VIOL_BIT];
   wire next_viol_flag = cmd_viol | (viol_flag & ~viol_clr);

   wire [7:0] irq_events = {6'h00, protect_drop, cmd_viol};
   wire [7:0] irq_clr    = wr_irq_st ? (i_wdata & IRQ_IMPL_MASK) : 8'h00;
   wire [7:0] next_irq_status = irq_events | (irq_status & ~irq_clr);
   wire       next_irq  = |(next_irq_status & irq_mask);

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [7:0] status_view = {3'h0, viol_flag, 4'h0};
   wire [7:0] next_rdata  =
      ~i_rd       ? 8'h00 :
      sel_status  ? status_view :
      sel_protect ? protect_ctrl :
      sel_irq_st  ? irq_status :
      sel_irq_msk ? irq_mask : 8'h00;

   // ---------------------------------------------------------------
   // protection register and load sequencing
   // ---------------------------------------------------------------
   // stays fully protected until the nonvolatile byte is in; the load
   // is taken once, later pulses on the load input are ignored
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         protect_ctrl <= PROTECT_RESET;
         loaded       <= 1'b0;
      end else if (!loaded) begin
         if (i_nv_valid) begin
            protect_ctrl <= i_nv_dbl_fault ? PROTECT_DBL_FAULT
                                           : i_nv_byte;
            loaded       <= 1'b1;
         end
      end else if (protect_take) begin
         protect_ctrl <= prop_ctrl;
      end
   end

   // ---------------------------------------------------------------
   // violation flag, interrupt status and mask
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         viol_flag  <= 1'b0;
         irq_status <= 8'h00;
         irq_mask   <= 8'h00;
      end else begin
         viol_flag  <= next_viol_flag;
         irq_status <= next_irq_status;
         if (wr_irq_msk) begin
            irq_mask <= i_wdata & IRQ_IMPL_MASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   // launch block follows the next flag value so it is never a cycle late
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata          <= 8'h00;
         o_verdict        <= '0;
         o_launch_block   <= 1'b1;
         o_loaded         <= 1'b0;
         o_irq            <= 1'b0;
      end else begin
         o_rdata          <= next_rdata;
         o_verdict.grant  <= cmd_grant;
         o_verdict.refuse <= cmd_refuse;
         o_launch_block   <= next_viol_flag | ~(loaded | i_nv_valid);
         o_loaded         <= loaded | i_nv_valid;
         o_irq            <= next_irq;
      end
   end

endmodule
`default_nettype wire

// [bench/pfp_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// port-level checks on the protection block
// ---------------------------------------------
module pfp_checker (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_b,
   input  wire logic                          i_rd,
   input  wire logic                          i_nv_valid,
   input  wire pfp_pkg::pfp_cmd_type          i_cmd,
   input  wire logic [pfp_pkg::DATA_W-1:0]    o_rdata,
   input  wire pfp_pkg::pfp_verdict_type      o_verdict,
   input  wire logic                          o_loaded,
   input  wire logic                          o_launch_block
);
   import pfp_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // a refusal lands exactly one edge after the request
   sequence s_refused;
      ##1 o_verdict.refuse;
   endsequence
   chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data present outside its slot");
   chk_verdict_one: assert property ($past(i_cmd.valid) |-> o_verdict.grant ^ o_verdict.refuse)
      else $error("command not answered by exactly one verdict");
   chk_verdict_idle: assert property (!$past(i_cmd.valid) |-> o_verdict == 2'b00)
      else $error("verdict without a command");
   chk_early_refuse: assert property (i_cmd.valid && !o_loaded |-> s_refused)
      else $error("command granted before the protection byte");
   chk_load_taken: assert property (i_nv_valid && !o_loaded |=> o_loaded)
      else $error("protection byte not taken");
   chk_load_holds: assert property (o_loaded |=> o_loaded)
      else $error("loaded indication dropped");
   chk_block_early: assert property (!o_loaded |-> o_launch_block)
      else $error("launch open before load");
   // a refusal while launch was open can only be a fresh protected hit,
   // and that hit must raise the flag even against a same-cycle clear
   chk_refuse_blocks: assert property (o_verdict.refuse && !$past(o_launch_block) |-> o_launch_block)
      else $error("refusal of an open launch without violation flag");
   chk_grant_clear: assert property (o_verdict.grant |-> !o_launch_block && !$past(o_launch_block))
      else $error("grant while launch blocked");
endmodule
bind pfp_protect pfp_checker i_chk (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .i_nv_valid(i_nv_valid), .i_cmd(i_cmd),
   .o_rdata(o_rdata), .o_verdict(o_verdict), .o_loaded(o_loaded), .o_launch_block(o_launch_block)
);
`default_nettype wire

// [bench/pfp_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// flash controller stand-in
// ---------------------------------------------
module pfp_ctrl_model (
   input  wire logic                      i_clk,
   input  wire pfp_pkg::pfp_verdict_type  i_verdict,
   output var  pfp_pkg::pfp_cmd_type      o_cmd
);
   import pfp_pkg::*;
   // one-cycle request; address scrambled after so nothing stale is seen
   task automatic issue(input pfp_op_type op, input logic [17:0] a, output pfp_verdict_type v);
      @(posedge i_clk);
      o_cmd <= '{1'b1, op, a};
      @(posedge i_clk);
      o_cmd <= '{1'b0, PFP_OP_OTHER, ~a};
      #1 v = i_verdict;
   endtask
   initial o_cmd = '0;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// protection register bench
// ---------------------------------------------
module tb_top;
   import pfp_pkg::*;
   logic            i_clk, i_rst_b, i_wr, i_rd, i_nv_valid, i_nv_dbl_fault;
   logic [15:0]     i_addr;
   logic [7:0]      i_wdata, i_nv_byte, o_rdata;
   logic            o_loaded, o_launch_block, o_irq;
   pfp_cmd_type     i_cmd;
   pfp_verdict_type o_verdict;
   int              fail_count = 0, n_checks = 0, cyc = 0;
   pfp_protect i_pfp_protect (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_nv_valid(i_nv_valid), .i_nv_byte(i_nv_byte),
      .i_nv_dbl_fault(i_nv_dbl_fault), .o_loaded(o_loaded), .i_cmd(i_cmd), .o_verdict(o_verdict),
      .o_launch_block(o_launch_block), .o_irq(o_irq));
   pfp_ctrl_model u_ctrl (.i_clk(i_clk), .i_verdict(o_verdict), .o_cmd(i_cmd));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // hang guard: the sequence needs about a hundred cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk8(o_rdata, e);
   endtask
   // g high: grant expected, else refuse
   task automatic cmd(input pfp_op_type op, input logic [17:0] a, input logic g);
      pfp_verdict_type v;
      u_ctrl.issue(op, a, v);
      chk8({6'h0, v}, {6'h0, g, ~g});
   endtask
   // loaded, launch block, irq; waits so registered levels settle
   task automatic flags(input logic [7:0] e);
      repeat (2) @(posedge i_clk);
      #1 chk8({5'h0, o_loaded, o_launch_block, o_irq}, e);
   endtask
   task automatic rst();
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
   endtask
   task automatic ld(input logic [7:0] b, input logic f);
      @(posedge i_clk);
      i_nv_valid <= 1'b1;
      i_nv_byte <= b;
      i_nv_dbl_fault <= f;
      @(posedge i_clk);
      i_nv_valid <= 1'b0;
      i_nv_byte <= ~b;
      i_nv_dbl_fault <= 1'b0;
   endtask
   task automatic clr();
      wr(FLASH_STATUS_REG_OFS, 8'h10);
      wr(IRQ_STATUS_OFS, 8'h03);
   endtask
   // main sequence: walks protection scenarios, refusals and clears
   initial begin
      {i_rst_b, i_wr, i_rd, i_nv_valid, i_nv_dbl_fault} = '0;
      {i_addr, i_wdata, i_nv_byte} = '0;
      rst();
      flags(8'h02);
      rd(PROTECT_CTRL_OFS, 8'h7F);
      wr(PROTECT_CTRL_OFS, 8'hFF);
      cmd(PFP_OP_OTHER, 18'h3_0000, 1'b0);
      ld(8'hFF, 1'b0);
      flags(8'h04);
      rd(PROTECT_CTRL_OFS, 8'hFF);
      cmd(PFP_OP_BLOCK_ERASE, 18'h3_8000, 1'b1);
      wr(IRQ_MASK_OFS, 8'h03);
      wr(PROTECT_CTRL_OFS, 8'hE1);
      rd(PROTECT_CTRL_OFS, 8'hE1);
      cmd(PFP_OP_PROGRAM, 18'h3_87FF, 1'b0);
      flags(8'h07);
      rd(FLASH_STATUS_REG_OFS, 8'h10);
      cmd(PFP_OP_PROGRAM, 18'h3_8800, 1'b0);
      clr();
      cmd(PFP_OP_PROGRAM, 18'h3_8800, 1'b1);
      cmd(PFP_OP_BLOCK_ERASE, 18'h3_C000, 1'b0);
      clr();
      wr(PROTECT_CTRL_OFS, 8'hDC);
      wr(PROTECT_CTRL_OFS, 8'hE3);
      rd(PROTECT_CTRL_OFS, 8'hE1);
      rd(IRQ_STATUS_OFS, 8'h02);
      wr(IRQ_STATUS_OFS, 8'h02);
      wr(PROTECT_CTRL_OFS, 8'hC9);
      rd(PROTECT_CTRL_OFS, 8'hC9);
      // high window now active: a new size must not land
      wr(PROTECT_CTRL_OFS, 8'hD9);
      rd(PROTECT_CTRL_OFS, 8'hC9);
      cmd(PFP_OP_PROGRAM, 18'h3_EFFF, 1'b1);
      cmd(PFP_OP_SECTOR_ERASE, 18'h3_F000, 1'b0);
      clr();
      cmd(PFP_OP_OTHER, 18'h3_F000, 1'b1);
      rd(16'h0200, 8'h00);
      flags(8'h04);
      rst();
      ld(8'h00, 1'b1);
      rd(PROTECT_CTRL_OFS, 8'h7F);
      cmd(PFP_OP_PROGRAM, 18'h3_8000, 1'b0);
      rst();
      ld(8'h5B, 1'b0);
      cmd(PFP_OP_PROGRAM, 18'h3_C000, 1'b1);
      cmd(PFP_OP_PROGRAM, 18'h3_BFFF, 1'b0);
      clr();
      wr(PROTECT_CTRL_OFS, 8'h7F);
      wr(PROTECT_CTRL_OFS, 8'hFF);
      rd(PROTECT_CTRL_OFS, 8'h7F);
      close_out();
   end
endmodule
`default_nettype wire
